// file: rsg_pkg.sv
// Purpose: Shared constants and types for the reset-state guard
// Assumes: 8-bit core registers, AHB-Lite word-aligned register map
// Notes:   Undefined reset contents are loaded as zero
package rsg_pkg;

   // Register byte offsets
   localparam logic [7:0] RSG_OFS_WDOG_CTRL  = 8'h00;
   localparam logic [7:0] RSG_OFS_FLAGS      = 8'h04;
   localparam logic [7:0] RSG_OFS_CAUSE      = 8'h08;
   localparam logic [7:0] RSG_OFS_IRQ_STAT   = 8'h0c;
   localparam logic [7:0] RSG_OFS_IRQ_EN     = 8'h10;
   localparam logic [7:0] RSG_OFS_IRQ_CLR    = 8'h14;
   localparam logic [7:0] RSG_OFS_CORE_BASE  = 8'h40;

   // Watchdog control field layout and keys
   localparam logic [7:0] RSG_WDOG_CTRL_RST  = 8'h53;
   localparam int         RSG_KEY_MSB        = 7;
   localparam int         RSG_KEY_LSB        = 3;
   localparam logic [4:0] RSG_KEY_DISABLE    = 5'h15;
   localparam logic [4:0] RSG_KEY_ENABLE     = 5'h0a;
   localparam int         RSG_SEL_MSB        = 2;

   // Flag positions in the flag register
   localparam int         RSG_FLAG_TOUT_BIT  = 5;
   localparam int         RSG_FLAG_PD_BIT    = 4;

   // Core register indices
   localparam int RSG_NCORE = 15;
   localparam int RSG_IX_MEM_PTR0    = 0;
   localparam int RSG_IX_MEM_PTR1    = 1;
   localparam int RSG_IX_ACCUM       = 2;
   localparam int RSG_IX_PC_LOW      = 3;
   localparam int RSG_IX_TBL_PTR_LO  = 4;
   localparam int RSG_IX_TBL_DATA_HI = 5;
   localparam int RSG_IX_TBL_PTR_HI  = 6;
   localparam int RSG_IX_BANK        = 7;
   localparam int RSG_IX_SYS_MODE    = 8;
   localparam int RSG_IX_EDGE_SEL    = 9;
   localparam int RSG_IX_VDET_CTRL   = 10;
   localparam int RSG_IX_IRQ_CTRL0   = 11;
   localparam int RSG_IX_MF_IRQ0     = 12;
   localparam int RSG_IX_PORT_A      = 13;
   localparam int RSG_IX_PORT_A_DIR  = 14;

   // Reset behaviour classes of a core register
   localparam logic [1:0] RSG_CLS_ZERO = 2'h0;  // Cleared on every reset
   localparam logic [1:0] RSG_CLS_DEF  = 2'h1;  // Defined value unless halt time-out
   localparam logic [1:0] RSG_CLS_KEEP = 2'h2;  // Only power-on loads it
   localparam logic [1:0] RSG_CLS_MPTR = 2'h3;  // Kept only by halt time-out

   // Per-entry reset value, implemented-bit mask and class (index 0 rightmost)
   localparam logic [RSG_NCORE-1:0][7:0] RSG_CORE_RST = {
      8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [RSG_NCORE-1:0][7:0] RSG_CORE_MASK = {
      8'hff, 8'hff, 8'hff, 8'h7f, 8'h37, 8'h0f, 8'hff, 8'h03,
      8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
   localparam logic [RSG_NCORE-1:0][1:0] RSG_CORE_CLS = {
      RSG_CLS_DEF, RSG_CLS_DEF, RSG_CLS_DEF, RSG_CLS_DEF, RSG_CLS_DEF, RSG_CLS_DEF,
      RSG_CLS_DEF, RSG_CLS_DEF, RSG_CLS_KEEP, RSG_CLS_KEEP, RSG_CLS_KEEP,
      RSG_CLS_ZERO, RSG_CLS_KEEP, RSG_CLS_MPTR, RSG_CLS_MPTR};

   // Analogue pin selection after a defined reset
   localparam logic [7:0] RSG_ANALOG_SEL_RST = 8'hff;

   // Reset cause, one-hot
   typedef enum logic [6:0] {
      RSG_CS_NONE     = 7'b0000001,
      RSG_CS_PIN      = 7'b0000010,
      RSG_CS_LOWV      = 7'b0000100,
      RSG_CS_USB      = 7'b0001000,
      RSG_CS_SOFT     = 7'b0010000,
      RSG_CS_WDOG_RUN  = 7'b0100000,
      RSG_CS_WDOG_HALT = 7'b1000000
   } rsg_cause_t;
   localparam int RSG_NEVT = 6;

   // Core state handed to the processor
   typedef struct packed {
      logic [7:0] prog_counter_low;
      logic [1:0] bank_pointer;
      logic [7:0] system_mode_reg;
      logic [7:0] interrupt_control_zero;
      logic [7:0] port_a_data;
      logic [7:0] port_a_direction;
      logic [7:0] analog_pin_sel;
   } rsg_core_view_t;

endpackage

// file: rsg_reset_guard.sv
// Purpose: Reset-state guard: merges reset sources, keeps cause flags, loads core registers
// Assumes: rst_n is the power-on reset; pin, voltage and USB requests are asynchronous
// Notes:   Reads take one wait state, writes none
// Function
// - Decode control key: 10101 disables, 01010 enables, anything else resets.
// - Power-on reset clears time-out and power-down flags.
// - Pin, low-voltage or USB reset in run leaves both flags alone.
// - Watchdog time-out in run sets time-out flag, keeps power-down flag.
// - Watchdog time-out in halt sets both flags.
// - Flags live in status and follow halt entry and watchdog events.
// - Power-on reset restarts the program counter at zero.
// - Every reset but a halt time-out disables every interrupt source until software enables it; irq_en_reg of the reset-event interrupt clears only at power-on.
// - Reset clears the watchdog counter, which then counts at once.
// - Reset switches all timer modules off.
// - Every reset but a halt time-out makes ports inputs and analogue pins converter inputs.
// - Low program-counter byte clears on every reset type.
// - Halt time-out keeps bank, mode, interrupt, port and control registers.
// - Other resets load bank 00, mode 03, ports ff, interrupt controls zero.
// - Accumulator and table registers kept except power-on; pointers kept only by halt time-out.
// - Flag pair reads 00 power-on, 1u run time-out, 01 halt pin, 11 halt time-out.
`timescale 1ns/1ps
module rsg_reset_guard #(
   parameter int WDOG_BASE_CYCLES = 8192,
   parameter int WDOG_CNT_W       = 24
) (
   // Clock and power-on reset
   input  wire logic                    mclk,
   input  wire logic                    rst_n,
   // AHB-Lite slave
   input  wire logic                    hsel,
   input  wire logic [31:0]             haddr,
   input  wire logic [1:0]              htrans,
   input  wire logic                    hwrite,
   input  wire logic [2:0]              hsize,
   input  wire logic [31:0]             hwdata,
   input  wire logic                    hready,
   output logic      [31:0]             hrdata,
   output logic                         hreadyout,
   output logic                         hresp,
   // Reset sources
   input  wire logic                    external_reset_pin_n,
   input  wire logic                    low_voltage_reset,
   input  wire logic                    usb_reset,
   // Processor status
   input  wire logic                    cpu_halted,
   input  wire logic                    halt_entry,
   input  wire logic                    clear_watchdog,
   // Reset outputs to the core
   output logic                         cpu_restart,
   output logic                         timers_off,
   output logic                         watchdog_running,
   output rsg_pkg::rsg_core_view_t      core_view,
   // Interrupt
   output logic                         irq
);
   import rsg_pkg::*;

   // Elaboration check; the longest selected period must still fit the counter
   if (WDOG_BASE_CYCLES < 1 || WDOG_CNT_W < 1 ||
       (longint'(WDOG_BASE_CYCLES) << ((1 << (RSG_SEL_MSB + 1)) - 1)) >= (longint'(1) << WDOG_CNT_W))
   begin : g_bad_period
      $error("watchdog base period does not fit the counter");
   end

   logic [2:0]            sync_meta_reg;
   logic [2:0]            sync_reg;
   rsg_cause_t            cause_reg;
   rsg_cause_t            cause_next;
   rsg_cause_t            last_cause_reg;
   logic                  halt_cap_reg;
   logic                  apply;
   logic                  wdog_halt;
   logic                  key_legal;
   logic                  wdog_enable;
   logic                  wdog_timeout;
   logic [WDOG_CNT_W-1:0] wdog_cnt_reg;
   logic [WDOG_CNT_W-1:0] wdog_limit;
   logic [7:0]            watchdog_control_reg;
   logic                  timeout_flag_reg;
   logic                  powerdown_flag_reg;
   logic [7:0]            core_reg [RSG_NCORE];
   logic [7:0]            analog_sel_reg;
   logic [RSG_NEVT-1:0]   irq_stat_reg;
   logic [RSG_NEVT-1:0]   irq_en_reg;
   logic                  cpu_restart_reg;
   logic                  timers_off_reg;
   logic                  wr_pend_reg;
   logic                  rd_pend_reg;
   logic [7:0]            addr_reg;
   logic [31:0]           hrdata_reg;
   logic [31:0]           rd_mux;
   logic                  wr_now;
   logic                  pin_req;

   // Two-flop synchronisers for the asynchronous reset requests
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sync_meta_reg <= 3'h0;
         sync_reg      <= 3'h0;
      end else begin
         sync_meta_reg <= {usb_reset, low_voltage_reset, !external_reset_pin_n};
         sync_reg      <= sync_meta_reg;
      end
   end
   assign pin_req = sync_reg[0];

   // Key decode; an illegal key is a software reset request
   assign key_legal   = (watchdog_control_reg[RSG_KEY_MSB:RSG_KEY_LSB] == RSG_KEY_DISABLE) ||
                        (watchdog_control_reg[RSG_KEY_MSB:RSG_KEY_LSB] == RSG_KEY_ENABLE);
   assign wdog_enable = (watchdog_control_reg[RSG_KEY_MSB:RSG_KEY_LSB] == RSG_KEY_ENABLE);
   assign watchdog_running = wdog_enable;

   // Source priority; one cause at a time so every update sees the same reason
   always_comb begin
      cause_next = RSG_CS_NONE;
      if (pin_req) begin
         cause_next = RSG_CS_PIN;
      end else if (sync_reg[1]) begin
         cause_next = RSG_CS_LOWV;
      end else if (sync_reg[2]) begin
         cause_next = RSG_CS_USB;
      end else if (!key_legal) begin
         cause_next = RSG_CS_SOFT;
      end else if (wdog_timeout) begin
         cause_next = cpu_halted ? RSG_CS_WDOG_HALT : RSG_CS_WDOG_RUN;
      end
   end

   // Cause capture, then one apply cycle; a held request repeats the pair
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cause_reg    <= RSG_CS_NONE;
         halt_cap_reg <= 1'b0;
      end else if (cause_reg != RSG_CS_NONE) begin
         cause_reg    <= RSG_CS_NONE;
      end else begin
         cause_reg    <= cause_next;
         halt_cap_reg <= cpu_halted;
      end
   end
   assign apply    = (cause_reg != RSG_CS_NONE);
   assign wdog_halt = (cause_reg == RSG_CS_WDOG_HALT);

   // Last applied cause for software
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         last_cause_reg <= RSG_CS_NONE;
      end else if (apply) begin
         last_cause_reg <= cause_reg;
      end
   end

   // Watchdog counter; period doubles per select step
   assign wdog_limit   = WDOG_CNT_W'((longint'(WDOG_BASE_CYCLES) << watchdog_control_reg[RSG_SEL_MSB:0]) - 1);
   assign wdog_timeout = wdog_enable && (wdog_cnt_reg == wdog_limit);
   always_ff @(posedge mclk) begin
      if (!rst_n || apply || clear_watchdog || wdog_timeout || !wdog_enable) begin
         wdog_cnt_reg <= '0;
      end else begin
         wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
      end
   end

   // Watchdog control register; reloads on any reset but a halt time-out
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         watchdog_control_reg <= RSG_WDOG_CTRL_RST;
      end else if (apply) begin
         if (!wdog_halt) begin
            watchdog_control_reg <= RSG_WDOG_CTRL_RST;
         end
      end else if (wr_now && addr_reg == RSG_OFS_WDOG_CTRL) begin
         watchdog_control_reg <= hwdata[7:0];
      end
   end

   // Time-out and power-down flags
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         timeout_flag_reg   <= 1'b0;
         powerdown_flag_reg <= 1'b0;
      end else if (apply) begin
         unique case (cause_reg)
            RSG_CS_PIN: begin
               if (halt_cap_reg) begin
                  timeout_flag_reg   <= 1'b0;
                  powerdown_flag_reg <= 1'b1;
               end
            end
            RSG_CS_LOWV, RSG_CS_USB: begin
               timeout_flag_reg <= timeout_flag_reg;
            end
            RSG_CS_SOFT, RSG_CS_WDOG_RUN: begin
               timeout_flag_reg <= 1'b1;
            end
            RSG_CS_WDOG_HALT: begin
               timeout_flag_reg   <= 1'b1;
               powerdown_flag_reg <= 1'b1;
            end
            RSG_CS_NONE: begin
            end
         endcase
      end else if (halt_entry) begin
         timeout_flag_reg   <= 1'b0;
         powerdown_flag_reg <= 1'b1;
      end else if (clear_watchdog) begin
         timeout_flag_reg   <= 1'b0;
         powerdown_flag_reg <= 1'b0;
      end
   end

   // Core registers, each loaded per its reset class
   for (genvar i = 0; i < RSG_NCORE; i++) begin : g_core
      always_ff @(posedge mclk) begin
         if (!rst_n) begin
            core_reg[i] <= RSG_CORE_RST[i];
         end else if (apply) begin
            unique case (RSG_CORE_CLS[i])
               RSG_CLS_ZERO: core_reg[i] <= 8'h00;
               RSG_CLS_DEF:  core_reg[i] <= wdog_halt ? core_reg[i] : RSG_CORE_RST[i];
               RSG_CLS_KEEP: core_reg[i] <= core_reg[i];
               RSG_CLS_MPTR: core_reg[i] <= wdog_halt ? core_reg[i] : RSG_CORE_RST[i];
            endcase
         end else if (wr_now && addr_reg == RSG_OFS_CORE_BASE + 8'(4 * i)) begin
            core_reg[i] <= hwdata[7:0] & RSG_CORE_MASK[i];
         end
      end
   end

   // Analogue pin function; no bus access, restored on defined resets
   always_ff @(posedge mclk) begin
      if (!rst_n || (apply && !wdog_halt)) begin
         analog_sel_reg <= RSG_ANALOG_SEL_RST;
      end
   end

   // Restart and timer-off strobes; held through power-on reset
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cpu_restart_reg <= 1'b1;
         timers_off_reg  <= 1'b1;
      end else begin
         cpu_restart_reg <= apply;
         timers_off_reg  <= apply;
      end
   end
   assign cpu_restart = cpu_restart_reg;
   assign timers_off  = timers_off_reg;

   // Core view; interrupt control zero keeps sources off after reset
   assign core_view.prog_counter_low       = core_reg[RSG_IX_PC_LOW];
   assign core_view.bank_pointer           = core_reg[RSG_IX_BANK][1:0];
   assign core_view.system_mode_reg        = core_reg[RSG_IX_SYS_MODE];
   assign core_view.interrupt_control_zero = core_reg[RSG_IX_IRQ_CTRL0];
   assign core_view.port_a_data            = core_reg[RSG_IX_PORT_A];
   assign core_view.port_a_direction       = core_reg[RSG_IX_PORT_A_DIR];
   assign core_view.analog_pin_sel         = analog_sel_reg;

   // Reset event interrupt; a new event beats a clear in the same cycle
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         irq_stat_reg <= '0;
         irq_en_reg   <= '0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~((wr_now && addr_reg == RSG_OFS_IRQ_CLR) ? hwdata[RSG_NEVT-1:0] : '0))
                         | (apply ? cause_reg[RSG_NEVT:1] : '0);
         if (wr_now && addr_reg == RSG_OFS_IRQ_EN) begin
            irq_en_reg <= hwdata[RSG_NEVT-1:0];
         end
      end
   end
   assign irq = |(irq_stat_reg & irq_en_reg);

   // AHB address phase capture
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
      end else begin
         if (hready) begin
            wr_pend_reg <= hsel && htrans[1] && hwrite;
            rd_pend_reg <= hsel && htrans[1] && !hwrite;
            if (hsel && htrans[1]) begin
               addr_reg <= haddr[7:0];
            end
         end else begin
            rd_pend_reg <= 1'b0;
         end
      end
   end
   assign wr_now = wr_pend_reg && hready;

   // Read mux; unmapped and write-only offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (addr_reg)
         RSG_OFS_WDOG_CTRL: rd_mux[7:0] = watchdog_control_reg;
         RSG_OFS_FLAGS: begin
            rd_mux[RSG_FLAG_TOUT_BIT] = timeout_flag_reg;
            rd_mux[RSG_FLAG_PD_BIT] = powerdown_flag_reg;
         end
         RSG_OFS_CAUSE:     rd_mux[6:0] = last_cause_reg;
         RSG_OFS_IRQ_STAT:  rd_mux[RSG_NEVT-1:0] = irq_stat_reg;
         RSG_OFS_IRQ_EN:    rd_mux[RSG_NEVT-1:0] = irq_en_reg;
         default: begin
            for (int k = 0; k < RSG_NCORE; k++) begin
               if (addr_reg == RSG_OFS_CORE_BASE + 8'(4 * k)) begin
                  rd_mux[7:0] = core_reg[k];
               end
            end
         end
      endcase
   end

   // Read data from a flop, filled during the wait state
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (rd_pend_reg) begin
         hrdata_reg <= rd_mux;
      end
   end
   assign hrdata    = hrdata_reg;
   assign hreadyout = !rd_pend_reg;
   assign hresp     = 1'b0;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_illegal_key_reset: assert property ((cause_reg == RSG_CS_NONE) && !key_legal && (sync_reg == 3'h0)
                                         |=> cause_reg == RSG_CS_SOFT)
      else $error("illegal key did not raise a software reset");
   a_por_flags_clear: assert property (@(posedge mclk) disable iff (1'b0)
                                       !rst_n |=> !timeout_flag_reg && !powerdown_flag_reg)
      else $error("power-on reset left a flag set");
   a_run_reset_keeps: assert property (apply && (cause_reg == RSG_CS_LOWV || cause_reg == RSG_CS_USB ||
                                       (cause_reg == RSG_CS_PIN && !halt_cap_reg))
                                       |=> $stable(timeout_flag_reg) && $stable(powerdown_flag_reg))
      else $error("run reset changed a flag");
   a_run_timeout_flags: assert property (apply && cause_reg == RSG_CS_WDOG_RUN
                                         |=> timeout_flag_reg && $stable(powerdown_flag_reg))
      else $error("run time-out flags wrong");
   a_halt_timeout_flags: assert property (apply && wdog_halt |=> timeout_flag_reg && powerdown_flag_reg)
      else $error("halt time-out flags wrong");
   a_halt_entry_flags: assert property (halt_entry && !apply |=> powerdown_flag_reg && !timeout_flag_reg)
      else $error("halt entry did not mark power-down");
   a_pc_low_zero: assert property (apply |=> core_reg[RSG_IX_PC_LOW] == 8'h00 && cpu_restart)
      else $error("program counter byte not cleared");
   a_halt_keeps_regs: assert property (apply && wdog_halt |=> $stable(core_reg[RSG_IX_SYS_MODE]) &&
                                       $stable(core_reg[RSG_IX_PORT_A_DIR]) &&
                                       $stable(core_reg[RSG_IX_MEM_PTR0]))
      else $error("halt time-out changed a kept register");
   a_defined_load: assert property (apply && !wdog_halt |=> core_reg[RSG_IX_SYS_MODE] == 8'h03 &&
                                    core_reg[RSG_IX_PORT_A] == 8'hff && core_reg[RSG_IX_IRQ_CTRL0] == 8'h00 &&
                                    core_reg[RSG_IX_BANK] == 8'h00)
      else $error("defined reset values not loaded");
   a_accum_kept: assert property (apply |=> $stable(core_reg[RSG_IX_ACCUM]) &&
                                  $stable(core_reg[RSG_IX_TBL_PTR_LO]))
      else $error("accumulator or table pointer lost on reset");
   a_wdog_cleared: assert property (apply |=> wdog_cnt_reg == '0 ##1 (!wdog_enable || wdog_cnt_reg == 1))
      else $error("watchdog counter not restarted");
   a_cause_pairs: assert property (apply |=> !apply)
      else $error("reset apply lasted more than one cycle");
   a_pin_priority: assert property ((cause_reg == RSG_CS_NONE) && pin_req |=> cause_reg == RSG_CS_PIN)
      else $error("pin request lost its priority");

   c_halt_timeout: cover property (apply && wdog_halt);
   c_soft_reset:   cover property (apply && cause_reg == RSG_CS_SOFT);
   c_pin_in_halt:  cover property (apply && cause_reg == RSG_CS_PIN && halt_cap_reg);
   c_read_flags:   cover property (rd_pend_reg && addr_reg == RSG_OFS_FLAGS);
endmodule

// file: rsg_src_model.sv
// Purpose: Reset source model for pin, low-voltage and USB requests
// Assumes: One request at a time, driven from the same clock
// Notes:   Lines idle inactive; a request is held long enough to cross the syncs
`timescale 1ns/1ps
module rsg_src_model #(
   parameter int HOLD = 3
) (
   // Clock and command
   input  wire logic       mclk,
   input  wire logic       go,
   input  wire logic [1:0] kind,
   // Reset request lines
   output logic            pin_n,
   output logic            low_v,
   output logic            usb
);
   int         cnt = 0;
   logic [1:0] kind_reg = 2'h0;
   // Hold counter; a short pulse could be missed by the two sync flops
   always_ff @(posedge mclk) begin
      cnt <= go ? HOLD : (cnt != 0 ? cnt - 1 : 0);
      kind_reg <= go ? kind : kind_reg;
   end
   // Only the chosen line is active while the counter runs
   assign pin_n = !(cnt != 0 && kind_reg == 2'h0);
   assign low_v = cnt != 0 && kind_reg == 2'h1;
   assign usb   = cnt != 0 && kind_reg == 2'h2;
endmodule

// file: rsg_reset_guard_tb.sv
// Purpose: Self-checking bench for the reset-state guard
// Assumes: Short watchdog base count so time-outs come quickly
// Notes:   Bus signals are sampled at the falling edge, stable until the next rise
`timescale 1ns/1ps
module rsg_reset_guard_tb;
   import rsg_pkg::*;
   localparam logic [49:0] DEF_VIEW = {8'h00, 2'h0, 8'h03, 8'h00, 8'hff, 8'hff, 8'hff};
   logic           mclk = 0, rst_n = 0, hsel = 0, hwrite = 0, halted = 0, h_entry = 0, clr_wd = 0, go = 0;
   logic [31:0]    haddr = 0, hwdata = 0, hrdata, accum_v;
   logic [1:0]     htrans = 0, kind = 0;
   logic           hreadyout, hresp, pin_n, low_v, usb, restart, t_off, wd_run, irq;
   logic [4:0]     key;
   rsg_core_view_t cv;
   int             fails = 0, total_checks = 0, seed = 95934;
   always #12.5 mclk = ~mclk;
   rsg_src_model i_src (.mclk(mclk), .go(go), .kind(kind), .pin_n(pin_n), .low_v(low_v), .usb(usb));
   rsg_reset_guard #(.WDOG_BASE_CYCLES(64)) i_dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .external_reset_pin_n(pin_n), .low_voltage_reset(low_v),
      .usb_reset(usb), .cpu_halted(halted), .halt_entry(h_entry), .clear_watchdog(clr_wd),
      .cpu_restart(restart), .timers_off(t_off), .watchdog_running(wd_run), .core_view(cv), .irq(irq));
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One single AHB transfer; request held until hready is seen high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(negedge mclk); while (hreadyout !== 1'b1);
      @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(negedge mclk); while (hreadyout !== 1'b1);
      q = hrdata;
      chk("hresp", 0, hresp);
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(nm, e, q);
   endtask
   function automatic logic [7:0] core_a(input int i);
      return RSG_OFS_CORE_BASE + 8'(4 * i);
   endfunction
   // Bounded wait for the restart pulse, then let repeated applies settle
   task automatic wait_restart();
      int n;
      n = 0;
      do begin @(negedge mclk); n++; end while (restart !== 1'b1 && n < 400);
      chk("restart_timers_off", 2'h3, {restart, t_off});
      repeat (12) @(posedge mclk);
   endtask
   task automatic pulse_src(input logic [1:0] k);
      go <= 1'b1;
      kind <= k;
      @(posedge mclk);
      go <= 1'b0;
      wait_restart();
   endtask
   task automatic sig(input string nm, input logic e, ref logic g);
      @(negedge mclk);
      chk(nm, e, g);
      @(posedge mclk);
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      complete_run();
   end
   initial begin
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rdc("wdog_ctrl", RSG_OFS_WDOG_CTRL, 32'h53);
      rdc("flags_por", RSG_OFS_FLAGS, 32'h0);
      chk("view_por", DEF_VIEW, cv);
      sig("wd_run", 1'b1, wd_run);
      accum_v = {24'h0, 8'($random(seed))};
      wr(core_a(RSG_IX_ACCUM), accum_v);
      key = 5'($random(seed));
      if (key == RSG_KEY_ENABLE || key == RSG_KEY_DISABLE) key = 5'h1f;
      wr(RSG_OFS_WDOG_CTRL, {24'h0, key, 3'h3});
      wait_restart();
      rdc("flags_soft", RSG_OFS_FLAGS, 32'h20);
      rdc("cause_soft", RSG_OFS_CAUSE, 32'h10);
      rdc("accum_kept", core_a(RSG_IX_ACCUM), accum_v);
      rdc("ctrl_reload", RSG_OFS_WDOG_CTRL, 32'h53);
      rdc("irq_stat_soft", RSG_OFS_IRQ_STAT, 32'h08);
      wr(RSG_OFS_IRQ_EN, 32'h3f);
      sig("irq_on", 1'b1, irq);
      wr(RSG_OFS_IRQ_EN, 32'h0);
      sig("irq_masked", 1'b0, irq);
      wr(RSG_OFS_IRQ_EN, 32'h3f);
      wr(RSG_OFS_IRQ_CLR, 32'h3f);
      sig("irq_cleared", 1'b0, irq);
      for (int k = 0; k < 3; k++) begin
         pulse_src(2'(k));
         rdc("flags_run", RSG_OFS_FLAGS, 32'h20);
         rdc("cause_src", RSG_OFS_CAUSE, 32'h2 << k);
         chk("view_def", DEF_VIEW, cv);
      end
      halted <= 1'b1;
      pulse_src(2'h0);
      halted <= 1'b0;
      rdc("flags_pin_halt", RSG_OFS_FLAGS, 32'h10);
      wr(core_a(RSG_IX_BANK), 32'h2);
      clr_wd <= 1'b1;
      @(posedge mclk);
      clr_wd <= 1'b0;
      rdc("flags_clear", RSG_OFS_FLAGS, 32'h0);
      wr(RSG_OFS_WDOG_CTRL, 32'h50);
      halted <= 1'b1;
      wait_restart();
      halted <= 1'b0;
      rdc("cause_halt", RSG_OFS_CAUSE, 32'h40);
      rdc("flags_halt", RSG_OFS_FLAGS, 32'h30);
      rdc("ctrl_kept", RSG_OFS_WDOG_CTRL, 32'h50);
      chk("view_halt", {8'h00, 2'h2, DEF_VIEW[39:0]}, cv);
      // Kept key still enables the short period, so a run time-out follows
      wait_restart();
      rdc("cause_run_to", RSG_OFS_CAUSE, 32'h20);
      rdc("flags_run_to", RSG_OFS_FLAGS, 32'h30);
      rdc("ctrl_run_to", RSG_OFS_WDOG_CTRL, 32'h53);
      wr(RSG_OFS_WDOG_CTRL, 32'hab);
      sig("wd_off", 1'b0, wd_run);
      h_entry <= 1'b1;
      @(posedge mclk);
      h_entry <= 1'b0;
      rdc("flags_entry", RSG_OFS_FLAGS, 32'h10);
      rdc("unmapped", 8'h3c, 32'h0);
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk);
      rdc("flags_por2", RSG_OFS_FLAGS, 32'h0);
      rdc("accum_por", core_a(RSG_IX_ACCUM), 32'h0);
      complete_run();
   end
endmodule
